// ### ccs_pkg.sv
// Package for the CPU clock source switch: register map, field layout, timing.
// Assumes one 200 MHz system clock shared by controller and device ends.
package ccs_pkg;
  // Clock control register offset in device I/O space
  localparam logic [15:0] CCS_CTRL_OFFSET = 16'hFF00;
  // Field positions
  localparam int CCS_BIT_GP = 0;
  localparam int CCS_BIT_UNUSED = 1;
  localparam int CCS_BIT_FAST_EN = 2;
  localparam int CCS_BIT_SELECT = 3;
  // Reset value of the register
  localparam logic [3:0] CCS_CTRL_RESET = 4'h0;
  // Stabilisation wait, in microseconds, and clock rate in MHz
  localparam int CCS_SETTLE_US = 5000;
  localparam int CCS_CLK_MHZ = 200;
  localparam int CCS_SETTLE_CYCLES = CCS_SETTLE_US * CCS_CLK_MHZ;
  // Instruction cycle times in nanoseconds for each source
  localparam int CCS_INSN_NS_32K = 61000;
  localparam int CCS_INSN_NS_60K = 33000;
  localparam int CCS_INSN_NS_FAST = 560;
  // Avalon register offsets (word index) of the controller
  localparam logic [1:0] CCS_AV_CMD = 2'h0;
  localparam logic [1:0] CCS_AV_STATUS = 2'h1;
  localparam logic [1:0] CCS_AV_RAW = 2'h2;
  // Command codes written to the command register
  localparam logic [1:0] CCS_CMD_TO_SLOW = 2'h1;
  localparam logic [1:0] CCS_CMD_TO_FAST = 2'h2;
  localparam logic [1:0] CCS_CMD_GP = 2'h3;
endpackage : ccs_pkg

// ### ccs_if.sv
// Interface joining the switching controller and the clock source device.
// Assumes both ends run on the same clock; a simple single-cycle write port.
interface ccs_if;
  logic wr_en;          // One-cycle register write strobe
  logic [15:0] addr;    // I/O address
  logic [3:0] wdata;    // Write data
  logic [3:0] rdata;    // Read data, combinational from device state
  modport device (input wr_en, input addr, input wdata, output rdata);
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
endinterface : ccs_if

// ### ccs_glitch_mux.sv
// Glitch-free selector between two clock-enable streams.
// Assumes both inputs are on-chip pulse streams in the system clock domain.
module ccs_glitch_mux
  import ccs_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sel_in,
  input wire logic slow_in,
  input wire logic fast_in,
  output logic clk_out,
  output logic on_fast_out
);
  import ccs_pkg::*;
  typedef struct packed {
    logic cur;   // Source currently passed
    logic out;   // Registered selected level
  } ccs_mux_t;
  ccs_mux_t st_ff, nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Switch only when both levels are low, so no runt pulse escapes
  always_comb
  begin
    nxt_st = st_ff;
    if (sel_in != st_ff.cur && !slow_in && !fast_in && !st_ff.out)
    begin
      nxt_st.cur = sel_in;
    end
    nxt_st.out = nxt_st.cur ? fast_in : slow_in;
  end

  // State register
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign clk_out = st_ff.out;
  assign on_fast_out = st_ff.cur;
endmodule : ccs_glitch_mux

// ### ccs_device.sv
// Clock source control register with fast-oscillator gate and CPU clock selector.
// Assumes slow and fast oscillator levels arrive from outside and need syncing.
module ccs_device
  import ccs_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  ccs_if.device bus,
  input wire logic slow_oscillator_in,
  input wire logic fast_oscillator_in,
  output logic fast_osc_run_out,
  output logic cpu_clk_out,
  output logic cpu_on_fast_out
);
  import ccs_pkg::*;
  typedef struct packed {
    logic [3:0] ctrl;   // Register image
    logic [1:0] s_slow; // Slow oscillator synchroniser
    logic [1:0] s_fast; // Fast oscillator synchroniser
  } ccs_dev_t;
  ccs_dev_t st_ff, nxt_st;
  logic fast_gated;

  ////////////////////////////////////////////////////////////////////////
  // Register writes and pin synchronisers
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s_slow = {st_ff.s_slow[0], slow_oscillator_in};
    nxt_st.s_fast = {st_ff.s_fast[0], fast_oscillator_in};
    if (bus.wr_en && bus.addr == CCS_CTRL_OFFSET)
    begin
      nxt_st.ctrl[CCS_BIT_FAST_EN] = bus.wdata[CCS_BIT_FAST_EN];
      nxt_st.ctrl[CCS_BIT_SELECT] = bus.wdata[CCS_BIT_SELECT];
      nxt_st.ctrl[CCS_BIT_GP] = bus.wdata[CCS_BIT_GP];
    end
    nxt_st.ctrl[CCS_BIT_UNUSED] = 1'b0;
  end

  // Reset clears both control bits: CPU starts on the slow source
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      st_ff <= '{ctrl: CCS_CTRL_RESET, s_slow: 2'h0, s_fast: 2'h0};
    else
      st_ff <= nxt_st;
  end

  // Read back; unmapped addresses return zero
  assign bus.rdata = (bus.addr == CCS_CTRL_OFFSET) ? st_ff.ctrl : 4'h0;
  // Stopped oscillator contributes a constant low level
  assign fast_gated = st_ff.s_fast[1] & st_ff.ctrl[CCS_BIT_FAST_EN];
  assign fast_osc_run_out = st_ff.ctrl[CCS_BIT_FAST_EN];

  // Instruction time follows the selected source frequency
  ccs_glitch_mux u_mux (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .sel_in(st_ff.ctrl[CCS_BIT_SELECT]),
    .slow_in(st_ff.s_slow[1]),
    .fast_in(fast_gated),
    .clk_out(cpu_clk_out),
    .on_fast_out(cpu_on_fast_out)
  );
endmodule : ccs_device

// ### ccs_ctrl.sv
// Switching sequencer: takes commands over Avalon-MM and drives the device port.
// Assumes software issues one command at a time and polls the busy flag.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
module ccs_ctrl
  import ccs_pkg::*;
#(
  parameter int SETTLE_CYCLES = CCS_SETTLE_CYCLES
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  ccs_if.ctrl dev,
  input wire logic [1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic busy_out
);
  import ccs_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_EN_ON, S_WAIT, S_SEL_ON, S_SEL_OFF, S_EN_OFF, S_GP
  } ccs_state_t;
  typedef struct packed {
    ccs_state_t state;
    logic [31:0] cnt;     // Settle counter
    logic [3:0] shadow;   // Last value written to the device
    logic gp;             // General-purpose bit to write
    logic wr;             // Device write strobe
    logic [31:0] rdata;   // Avalon read data
    logic wait_r;         // Avalon waitrequest
    logic ack;            // Accepted a bus cycle last edge
  } ccs_ctl_t;
  ccs_ctl_t st_ff, nxt_st;
  logic [3:0] img;

  ////////////////////////////////////////////////////////////////////////
  // Build a device word with chosen bits
  function automatic logic [3:0] mk(input logic sel, input logic en, input logic gp);
    logic [3:0] w;
    w = 4'h0;
    w[CCS_BIT_SELECT] = sel;
    w[CCS_BIT_FAST_EN] = en;
    w[CCS_BIT_GP] = gp;
    return w;
  endfunction : mk

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and bus slave; waitrequest drops for one cycle per access
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.wr = 1'b0;
    nxt_st.ack = 1'b0;
    nxt_st.wait_r = 1'b1;
    if ((avs_read_in || avs_write_in) && !st_ff.ack && st_ff.wait_r)
    begin
      nxt_st.wait_r = 1'b0;
      nxt_st.ack = 1'b1;
      nxt_st.rdata = 32'h0;
      if (avs_read_in)
      begin
        unique case (avs_address_in)
          CCS_AV_STATUS: nxt_st.rdata = {31'h0, st_ff.state != S_IDLE};
          CCS_AV_RAW: nxt_st.rdata = {28'h0, dev.rdata};
          default: nxt_st.rdata = 32'h0;
        endcase
      end
      else if (avs_address_in == CCS_AV_CMD && st_ff.state == S_IDLE)
      begin
        // Commands while busy are ignored
        unique case (avs_writedata_in[1:0])
          CCS_CMD_TO_FAST: nxt_st.state = S_EN_ON;
          CCS_CMD_TO_SLOW: nxt_st.state = S_SEL_OFF;
          CCS_CMD_GP:
          begin
            nxt_st.gp = avs_writedata_in[4];
            nxt_st.state = S_GP;
          end
          default: nxt_st.state = S_IDLE;
        endcase
      end
    end
    unique case (st_ff.state)
      S_IDLE: ;
      S_EN_ON:
      begin
        nxt_st.shadow = mk(1'b0, 1'b1, st_ff.shadow[CCS_BIT_GP]);
        nxt_st.wr = 1'b1;
        nxt_st.cnt = SETTLE_CYCLES;
        nxt_st.state = S_WAIT;
      end
      S_WAIT:
      begin
        // Count the full settle time; parameter can be raised for margin
        if (st_ff.cnt == 32'h0)
          nxt_st.state = S_SEL_ON;
        else
          nxt_st.cnt = st_ff.cnt - 32'h1;
      end
      S_SEL_ON:
      begin
        nxt_st.shadow = mk(1'b1, 1'b1, st_ff.shadow[CCS_BIT_GP]);
        nxt_st.wr = 1'b1;
        nxt_st.state = S_IDLE;
      end
      S_SEL_OFF:
      begin
        nxt_st.shadow = mk(1'b0, st_ff.shadow[CCS_BIT_FAST_EN], st_ff.shadow[CCS_BIT_GP]);
        nxt_st.wr = 1'b1;
        nxt_st.state = S_EN_OFF;
      end
      S_EN_OFF:
      begin
        // Second, separate write stops the oscillator to save current
        nxt_st.shadow = mk(1'b0, 1'b0, st_ff.shadow[CCS_BIT_GP]);
        nxt_st.wr = 1'b1;
        nxt_st.state = S_IDLE;
      end
      S_GP:
      begin
        nxt_st.shadow = mk(st_ff.shadow[CCS_BIT_SELECT], st_ff.shadow[CCS_BIT_FAST_EN], st_ff.gp);
        nxt_st.wr = 1'b1;
        nxt_st.state = S_IDLE;
      end
      default: nxt_st.state = S_IDLE;
    endcase
  end

  // State register; reset mirrors the device reset value
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      st_ff <= '0;
      st_ff.shadow <= CCS_CTRL_RESET;
      st_ff.wait_r <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign img = st_ff.shadow;
  assign dev.wr_en = st_ff.wr;
  assign dev.addr = CCS_CTRL_OFFSET;
  assign dev.wdata = img;
  assign avs_readdata_out = st_ff.rdata;
  assign avs_waitrequest_out = st_ff.wait_r;
  assign busy_out = (st_ff.state != S_IDLE);
endmodule : ccs_ctrl

// ### ccs_monitor.sv
// Checker for the link between sequencer and clock source register.
// Assumes one clock and a synchronous active-high reset; placed by the bench.
module ccs_monitor
#(
  parameter int SETTLE_CYCLES = 20
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wr_en,
  input wire logic [15:0] addr,
  input wire logic [3:0] wdata,
  input wire logic [3:0] rdata
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles the fast oscillator has been enabled; saturates so it never wraps
  int en_cnt_ff;
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !rdata[2])
      en_cnt_ff <= 0;
    else if (en_cnt_ff < SETTLE_CYCLES)
      en_cnt_ff <= en_cnt_ff + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Leaving the fast clock: select drops first, enable in the next write
  sequence select_drop_s;
    wr_en && rdata[3] && !wdata[3];
  endsequence
  sequence enable_drop_s;
    wr_en && wdata[3:2] == 2'b00;
  endsequence
  addr_fixed_a: assert property (wr_en |-> addr == 16'hFF00)
    else $error("write to another address");
  readback_a: assert property (wr_en |=> rdata == ($past(wdata) & 4'hD))
    else $error("register does not read back");
  hold_a: assert property (!wr_en |=> $stable(rdata))
    else $error("register changed without a write");
  reset_clear_a: assert property ($fell(rst_in) |-> rdata == 4'h0)
    else $error("register not clear after reset");
  settle_wait_a: assert property (wr_en && wdata[3] && !rdata[3] |-> en_cnt_ff >= SETTLE_CYCLES)
    else $error("select raised before settling");
  order_slow_a: assert property (wr_en && !wdata[2] |-> !wdata[3])
    else $error("enable dropped while select high");
  split_write_a: assert property (select_drop_s |-> wdata[2])
    else $error("select and enable cleared together");
  slow_off_a: assert property (select_drop_s |=> enable_drop_s)
    else $error("fast oscillator left running");
  unused_zero_a: assert property (rdata[1] == 1'b0)
    else $error("unused bit reads one");
endmodule : ccs_monitor

// ### ccs_bench.sv
// Bench: drives the sequencer over Avalon-MM and watches the clock outputs.
// Assumes one 200 MHz clock; the two oscillators are modelled as dividers here.
module ccs_bench
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic slow_osc = 1'b0;
  logic fast_osc = 1'b0;
  logic [7:0] osc_cnt = 8'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [1:0] av_a = 2'h0;
  logic [31:0] av_d = 32'h0;
  logic [31:0] av_q;
  logic [31:0] q;
  logic wait_n, busy, run, cpu_clk, on_fast;
  int fails, checks, cyc;
  ccs_if link();
  ccs_device ccs_device_i(.clock_in(clock_in), .rst_in(rst_in), .bus(link),
    .slow_oscillator_in(slow_osc), .fast_oscillator_in(fast_osc),
    .fast_osc_run_out(run), .cpu_clk_out(cpu_clk), .cpu_on_fast_out(on_fast));
  ccs_ctrl #(.SETTLE_CYCLES(SETTLE)) ccs_ctrl_i(.clock_in(clock_in), .rst_in(rst_in),
    .dev(link), .avs_address_in(av_a), .avs_read_in(av_rd), .avs_write_in(av_wr),
    .avs_writedata_in(av_d), .avs_readdata_out(av_q), .avs_waitrequest_out(wait_n),
    .busy_out(busy));
  ccs_monitor #(.SETTLE_CYCLES(SETTLE)) ccs_monitor_i(.clock_in(clock_in),
    .rst_in(rst_in), .wr_en(link.wr_en), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2.5 clock_in = ~clock_in;
  end
  // Oscillators: slow period 64 cycles, fast period 4; plus the hang guard
  always @(posedge clock_in)
  begin
    osc_cnt <= osc_cnt + 8'h01;
    fast_osc <= osc_cnt[1];
    slow_osc <= osc_cnt[5];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One bus access; the request is held until a rising edge samples waitrequest low.
  // Right after the edge the design's registers still show their pre-edge values,
  // so waitrequest and read data read here are what that edge samples.
  task av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_wr <= wr;
    av_rd <= !wr;
    av_a <= a;
    av_d <= d;
    do
    begin
      @(posedge clock_in);
      n++;
    end while (wait_n !== 1'b0 && n < 50);
    q = av_q;
    check("answer", 32'(n < 50), 32'h1);
    // Release at the answering edge, then let one edge pass before the next request
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clock_in);
  endtask : av
  task idle_wait;
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] && n < 100)
    begin
      av(1'b0, CCS_AV_STATUS, 32'h0);
      n++;
    end
    check("busy pin", 32'(busy), 32'h0);
  endtask : idle_wait
  task wait_fast(input logic v);
    int n;
    n = 0;
    while (on_fast !== v && n < 300)
    begin
      @(negedge clock_in);
      n++;
    end
    check("on fast", 32'(on_fast), 32'(v));
  endtask : wait_fast
  // Rising edges of the CPU clock over 256 system cycles
  task rises(input int lo, input int hi);
    int n;
    logic p;
    n = 0;
    p = cpu_clk;
    repeat (256)
    begin
      @(negedge clock_in);
      if (cpu_clk && !p)
        n++;
      p = cpu_clk;
    end
    check("cpu clock rises", 32'(n >= lo && n <= hi), 32'h1);
  endtask : rises
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    av(1'b0, CCS_AV_RAW, 32'h0);
    check("raw reset", q, 32'h0);
    check("run reset", 32'(run), 32'h0);
    rises(3, 4);
    $display("test reset done");
    av(1'b1, CCS_AV_CMD, 32'h13);
    av(1'b0, CCS_AV_RAW, 32'h0);
    check("raw gp", q, 32'h1);
    av(1'b1, CCS_AV_CMD, 32'h2);
    av(1'b1, CCS_AV_CMD, 32'h1);
    idle_wait();
    av(1'b0, CCS_AV_RAW, 32'h0);
    check("raw fast", q, 32'hD);
    check("run fast", 32'(run), 32'h1);
    wait_fast(1'b1);
    rises(62, 65);
    $display("test fast done");
    av(1'b1, CCS_AV_CMD, 32'h1);
    idle_wait();
    av(1'b0, CCS_AV_RAW, 32'h0);
    check("raw slow", q, 32'h1);
    check("run slow", 32'(run), 32'h0);
    wait_fast(1'b0);
    rises(3, 4);
    av(1'b1, CCS_AV_CMD, 32'h3);
    av(1'b0, CCS_AV_RAW, 32'h0);
    check("raw gp clear", q, 32'h0);
    av(1'b0, 2'h3, 32'h0);
    check("unmapped", q, 32'h0);
    $display("test slow done");
    close_out();
  end
endmodule : ccs_bench
